// ---- design/lp_clock_defs.vh ----
`ifndef LP_CLOCK_DEFS_VH
`define LP_CLOCK_DEFS_VH

// ==========================================================================
// Register byte offsets.
`define OFS_SYS_CLOCK_DIVIDER     16'h0408
`define OFS_CLOCK_GATE_ENABLE     16'h0410
`define OFS_CLOCK_SOURCE_SELECT   16'h0414
`define OFS_DIVIDER_UNLOCK_KEY    16'h0420
`define OFS_OSCILLATOR_UNLOCK_KEY 16'h0A0C
`define OFS_OSCILLATOR_CONTROL    16'h0A10
`define OFS_RESET_CTRL_UNLOCK_KEY 16'h0A5C
`define OFS_LOW_OSC_TEST          16'h0A6C
`define OFS_CHOP_WAKEUP_CLK_EN    16'h0A70
`define OFS_HIGH_SPEED_OSC_CONFIG 16'h20BC
`define OFS_LOW_POWER_UNLOCK_KEY  16'h210C
`define OFS_LOW_POWER_CLOCK_SEL   16'h2110
`define OFS_LOW_POWER_CONFIG      16'h2114

// ==========================================================================
// Reset values.
`define RST_SYS_CLOCK_DIVIDER     16'h0441
`define RST_CLOCK_GATE_ENABLE     16'h01C0
`define RST_CLOCK_SOURCE_SELECT   16'h0000
`define RST_OSCILLATOR_CONTROL    16'h0003
`define RST_LOW_OSC_TEST          16'h0088
`define RST_CHOP_WAKEUP_CLK_EN    16'h0004
`define RST_HIGH_SPEED_OSC_CONFIG 16'h0034
`define RST_LOW_POWER_KEY         20'h00000
`define RST_LOW_POWER_CLOCK_SEL   1'h0
`define RST_LOW_POWER_CONFIG      9'h102
`define RST_KEY16                 16'h0000

// ==========================================================================
// Key values and field layouts.
`define LOW_POWER_KEY_VALUE       20'hC59D6
`define DIVIDER_KEY_VALUE         16'hA815
`define LPC_WIDTH                 9
`define LPC_RESERVED_MASK         9'h1CF
`define LPC_REGULATOR_PD          8
`define LPC_COMMON_MODE_BUF       7
`define LPC_REFERENCE_BUF         6
`define LPC_REPEAT_CONV           3
`define LPC_CONV                  2
`define LPC_FAST_REF_PD           1
`define LPC_FAST_OSC_PD           0
`define DIV_FIELD_MSB             5
`define DIV_MAX                   6'h20
`define DIV_ONE                   6'h01
`define DIV_ZERO                  6'h00
`define SRC_SEL_SYS_MSB           1
`define SRC_SEL_ADC_LSB           2
`define SRC_SEL_MASK              16'h000F
`define SRC_FAST_INTERNAL         2'h0
`define SRC_EXT_CLOCK             2'h3
`define GATE_ANALOG_CLK_DIS       5
`define WAKE_TIMER_CLK_DIS        1
`define CHOP_CLK_DIS              2
`define CHOP_WAKE_MASK            16'h0007
`define HSOSC_32M_BIT             2

`endif

// ---- design/low_power_clock_key_control.v ----
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lp_clock_defs.vh"

// Functional notes
// R1: Protected writes succeed only while the 20-bit low power key equals the unlock value.
// R2: Writing any other key value, zero included, relocks the protected registers.
// R3: Key resets to zero (locked); protected writes while locked are silently ignored.
// R4: The low power key guards both clock select and low power configuration.
// R5: Clock select bit 0 lets the sequencer move system clock to slow oscillator.
// R6: Configuration bit 8 powers down the analog regulator; resets to one.
// R7: Bits 7 and 6 enable common-mode and reference buffers; reset to zero.
// R8: Bits 2 and 3 enable conversions and repeated conversions; reset to zero.
// R9: Bit 1 powers down fast reference (reset one); bit 0 fast oscillator (reset zero).
// R10: After reset the fast internal oscillator at 16 MHz drives the system clock.
// R11: Software divides the system clock by any factor from 1 to 32.
// R12: With a 32 MHz source software must program the divide field to 2.
// R13: The converter clock is never divided.
// R14: The sleep and wake-up timer runs from the slow internal oscillator.
// R15: The 32 MHz fast setting clocks only fast DAC, transimpedance amp and converter.
// R16: External clock enters on general pin two, or pin five on the larger variant.
// R17: A write-only divider key guards the clock divider register.
// R18: A readable oscillator key guards the oscillator control register.
// R19: A write-only reset control key guards the reset control register.
// R20: Divide values above 32 saturate to 32; values 0 and 1 both divide by 1.
// R21: Reads of protected registers return stored values regardless of lock state.
module low_power_clock_key_control #(
   parameter        HAS_PIN_FIVE    = 1,
   // Arbitrary neutral key values for the oscillator and reset control keys.
   parameter [15:0] OSC_KEY_VALUE   = 16'h0001,
   parameter [15:0] RESET_KEY_VALUE = 16'h0001
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [15:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   input  wire        sequencer_slow_request,
   input  wire        general_pin_two,
   input  wire        general_pin_five,
   output reg         sys_clk_use_slow,
   output reg  [1:0]  sys_clk_source,
   output reg  [1:0]  adc_clk_source,
   output reg  [5:0]  sys_clk_divide,
   output reg         sys_clk_tick,
   output reg         adc_clk_divided,
   output reg         ext_clk_level,
   output reg         sleep_timer_clk_enable,
   output reg         chop_clk_enable,
   output reg         analog_clk_enable,
   output reg         fast_32m_to_analog,
   output reg         fast_32m_to_digital,
   output reg  [15:0] oscillator_control_out,
   output reg         reset_control_unlocked,
   output reg         analog_regulator_powerdown,
   output reg         common_mode_buffer_enable,
   output reg         reference_buffer_enable,
   output reg         repeat_conversion_enable,
   output reg         conversion_enable,
   output reg         fast_reference_powerdown,
   output reg         fast_oscillator_powerdown
);

   // =======================================================================
   // Register storage.
   reg [19:0]              low_power_unlock_key_reg;
   reg                     slow_sysclk_switch_reg;
   reg [`LPC_WIDTH-1:0]    low_power_config_reg;
   reg [15:0]              sys_clock_divider_reg;
   reg [15:0]              clock_gate_enable_reg;
   reg [15:0]              clock_source_select_reg;
   reg [15:0]              oscillator_unlock_key_reg;
   reg [15:0]              oscillator_control_reg;
   reg [15:0]              low_osc_test_reg;
   reg [15:0]              chop_wakeup_clock_enable_reg;
   reg [15:0]              high_speed_osc_config_reg;

   reg                     divider_armed_reg;
   reg                     reset_armed_reg;

   reg [5:0]               tick_count_reg;
   reg [5:0]               tick_count_next;

   reg [2:0]               pin_two_sync_reg;
   reg [2:0]               pin_five_sync_reg;
   reg                     pin_two_level_reg;
   reg                     pin_five_level_reg;

   wire        wr_access;
   wire        rd_setup;
   wire        lp_unlocked;
   wire        osc_unlocked;
   wire [5:0]  divide_now;
   reg  [31:0] read_mux;
   reg         addr_hit;

   // =======================================================================
   // Divide field decoding.
   // R20: saturate divide field
   function [5:0] effective_divide;
      input [5:0] field;
      begin
         if (field == `DIV_ZERO) begin
            effective_divide = `DIV_ONE;
         end else if (field > `DIV_MAX) begin
            effective_divide = `DIV_MAX;
         end else begin
            effective_divide = field;
         end
      end
   endfunction

   // =======================================================================
   // APB handshake: zero wait states, data prepared in the setup cycle.
   assign pready    = 1'b1;
   assign wr_access = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable;

   // R1: key match unlock
   assign lp_unlocked  = (low_power_unlock_key_reg == `LOW_POWER_KEY_VALUE);

   // R18: oscillator key gate
   assign osc_unlocked = (oscillator_unlock_key_reg == OSC_KEY_VALUE);

   // R11: divide from register
   assign divide_now   = effective_divide(sys_clock_divider_reg[`DIV_FIELD_MSB:0]);

   // R21: reads ignore lock
   always @* begin
      read_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         `OFS_SYS_CLOCK_DIVIDER:     read_mux = {16'h0000, sys_clock_divider_reg};
         `OFS_CLOCK_GATE_ENABLE:     read_mux = {16'h0000, clock_gate_enable_reg};
         `OFS_CLOCK_SOURCE_SELECT:   read_mux = {16'h0000, clock_source_select_reg};
         `OFS_DIVIDER_UNLOCK_KEY:    read_mux = 32'h0000_0000;
         `OFS_OSCILLATOR_UNLOCK_KEY: read_mux = {16'h0000, oscillator_unlock_key_reg};
         `OFS_OSCILLATOR_CONTROL:    read_mux = {16'h0000, oscillator_control_reg};
         `OFS_RESET_CTRL_UNLOCK_KEY: read_mux = 32'h0000_0000;
         `OFS_LOW_OSC_TEST:          read_mux = {16'h0000, low_osc_test_reg};
         `OFS_CHOP_WAKEUP_CLK_EN:    read_mux = {16'h0000, chop_wakeup_clock_enable_reg};
         `OFS_HIGH_SPEED_OSC_CONFIG: read_mux = {16'h0000, high_speed_osc_config_reg};
         `OFS_LOW_POWER_UNLOCK_KEY:  read_mux = {12'h000, low_power_unlock_key_reg};
         `OFS_LOW_POWER_CLOCK_SEL:   read_mux = {31'h0000_0000, slow_sysclk_switch_reg};
         `OFS_LOW_POWER_CONFIG:      read_mux = {23'h00_0000, low_power_config_reg};
         default: begin
            read_mux = 32'h0000_0000;
            addr_hit = 1'b0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : read_mux;
         pslverr <= ~addr_hit;
      end
   end

   // =======================================================================
   // Register writes.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // R3: reset locked key
         low_power_unlock_key_reg     <= `RST_LOW_POWER_KEY;
         slow_sysclk_switch_reg       <= `RST_LOW_POWER_CLOCK_SEL;
         low_power_config_reg         <= `RST_LOW_POWER_CONFIG;

         // R10: fast oscillator default
         sys_clock_divider_reg        <= `RST_SYS_CLOCK_DIVIDER;
         clock_source_select_reg      <= `RST_CLOCK_SOURCE_SELECT;
         clock_gate_enable_reg        <= `RST_CLOCK_GATE_ENABLE;
         oscillator_unlock_key_reg    <= `RST_KEY16;
         oscillator_control_reg       <= `RST_OSCILLATOR_CONTROL;
         low_osc_test_reg             <= `RST_LOW_OSC_TEST;
         chop_wakeup_clock_enable_reg <= `RST_CHOP_WAKEUP_CLK_EN;
         high_speed_osc_config_reg    <= `RST_HIGH_SPEED_OSC_CONFIG;

         divider_armed_reg            <= 1'b0;
         reset_armed_reg              <= 1'b0;
      end else if (wr_access && addr_hit) begin
         case (paddr)
            // R2: any value relocks
            `OFS_LOW_POWER_UNLOCK_KEY: begin
               low_power_unlock_key_reg <= pwdata[19:0];
            end

            // R4: clock select guarded
            `OFS_LOW_POWER_CLOCK_SEL: begin
               if (lp_unlocked) begin
                  slow_sysclk_switch_reg <= pwdata[0];
               end
            end

            // R4: configuration guarded
            `OFS_LOW_POWER_CONFIG: begin
               if (lp_unlocked) begin
                  low_power_config_reg <= pwdata[`LPC_WIDTH-1:0] & `LPC_RESERVED_MASK;
               end
            end

            // R17: divider key arms
            `OFS_DIVIDER_UNLOCK_KEY: begin
               divider_armed_reg <= (pwdata[15:0] == `DIVIDER_KEY_VALUE);
            end

            `OFS_SYS_CLOCK_DIVIDER: begin
               if (divider_armed_reg) begin
                  sys_clock_divider_reg <= pwdata[15:0];
               end
               // Every divider write spends the arming, so each change needs a fresh key.
               divider_armed_reg <= 1'b0;
            end

            `OFS_OSCILLATOR_UNLOCK_KEY: begin
               oscillator_unlock_key_reg <= pwdata[15:0];
            end

            `OFS_OSCILLATOR_CONTROL: begin
               if (osc_unlocked) begin
                  oscillator_control_reg <= pwdata[15:0];
               end
            end

            // R19: reset key arms
            `OFS_RESET_CTRL_UNLOCK_KEY: begin
               reset_armed_reg <= (pwdata[15:0] == RESET_KEY_VALUE);
            end

            `OFS_CLOCK_SOURCE_SELECT: begin
               clock_source_select_reg <= pwdata[15:0] & `SRC_SEL_MASK;
            end

            `OFS_CLOCK_GATE_ENABLE: begin
               clock_gate_enable_reg <= pwdata[15:0];
            end

            `OFS_LOW_OSC_TEST: begin
               low_osc_test_reg <= pwdata[15:0];
            end

            `OFS_CHOP_WAKEUP_CLK_EN: begin
               chop_wakeup_clock_enable_reg <= pwdata[15:0] & `CHOP_WAKE_MASK;
            end

            `OFS_HIGH_SPEED_OSC_CONFIG: begin
               high_speed_osc_config_reg <= pwdata[15:0];
            end

            default: begin
               divider_armed_reg <= divider_armed_reg;
            end
         endcase
      end
   end

   // =======================================================================
   // External clock pins: three-stage synchronisers with agreement filter.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_two_sync_reg   <= 3'h0;
         pin_five_sync_reg  <= 3'h0;
         pin_two_level_reg  <= 1'b0;
         pin_five_level_reg <= 1'b0;
      end else begin
         pin_two_sync_reg  <= {pin_two_sync_reg[1:0], general_pin_two};
         pin_five_sync_reg <= {pin_five_sync_reg[1:0], general_pin_five};

         // Stage one may be metastable, so only stages two and three are compared.
         if (pin_two_sync_reg[1] == pin_two_sync_reg[2]) begin
            pin_two_level_reg <= pin_two_sync_reg[2];
         end

         if (pin_five_sync_reg[1] == pin_five_sync_reg[2]) begin
            pin_five_level_reg <= pin_five_sync_reg[2];
         end
      end
   end

   // =======================================================================
   // Divided system clock tick.
   always @* begin
      tick_count_next = tick_count_reg + 6'h01;

      if (tick_count_next >= divide_now) begin
         tick_count_next = 6'h00;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_count_reg <= 6'h00;
         sys_clk_tick   <= 1'b0;
      end else begin
         tick_count_reg <= tick_count_next;
         sys_clk_tick   <= (tick_count_next == 6'h00);
      end
   end

   // =======================================================================
   // Registered control outputs.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_clk_use_slow           <= 1'b0;
         sys_clk_source             <= `SRC_FAST_INTERNAL;
         adc_clk_source             <= `SRC_FAST_INTERNAL;
         sys_clk_divide             <= `DIV_ONE;
         adc_clk_divided            <= 1'b0;
         ext_clk_level              <= 1'b0;
         sleep_timer_clk_enable     <= 1'b0;
         chop_clk_enable            <= 1'b0;
         analog_clk_enable          <= 1'b0;
         fast_32m_to_analog         <= 1'b0;
         fast_32m_to_digital        <= 1'b0;
         oscillator_control_out     <= `RST_OSCILLATOR_CONTROL;
         reset_control_unlocked     <= 1'b0;

         analog_regulator_powerdown <= 1'b1;
         common_mode_buffer_enable  <= 1'b0;
         reference_buffer_enable    <= 1'b0;
         repeat_conversion_enable   <= 1'b0;
         conversion_enable          <= 1'b0;
         fast_reference_powerdown   <= 1'b1;
         fast_oscillator_powerdown  <= 1'b0;
      end else begin
         // R5: sequencer slow switch
         sys_clk_use_slow           <= slow_sysclk_switch_reg & sequencer_slow_request;
         sys_clk_source             <= clock_source_select_reg[`SRC_SEL_SYS_MSB:0];
         adc_clk_source             <= clock_source_select_reg[`SRC_SEL_ADC_LSB+1:`SRC_SEL_ADC_LSB];
         sys_clk_divide             <= divide_now;

         // The converter clock has no divider, so a 32 MHz source reaches it whole.
         // R13: converter clock undivided
         adc_clk_divided            <= 1'b0;

         // R16: pin five variant only
         ext_clk_level              <= (HAS_PIN_FIVE != 0) ? (pin_two_level_reg | pin_five_level_reg)
                                                           : pin_two_level_reg;

         // R14: timer on slow oscillator
         sleep_timer_clk_enable     <= ~chop_wakeup_clock_enable_reg[`WAKE_TIMER_CLK_DIS];
         chop_clk_enable            <= ~chop_wakeup_clock_enable_reg[`CHOP_CLK_DIS];
         analog_clk_enable          <= ~clock_gate_enable_reg[`GATE_ANALOG_CLK_DIS];

         // R15: 32 MHz analog only
         fast_32m_to_analog         <= high_speed_osc_config_reg[`HSOSC_32M_BIT];
         fast_32m_to_digital        <= 1'b0;
         oscillator_control_out     <= oscillator_control_reg;
         reset_control_unlocked     <= reset_armed_reg;

         // R6: regulator power-down bit
         analog_regulator_powerdown <= low_power_config_reg[`LPC_REGULATOR_PD];

         // R7: buffer enables
         common_mode_buffer_enable  <= low_power_config_reg[`LPC_COMMON_MODE_BUF];
         reference_buffer_enable    <= low_power_config_reg[`LPC_REFERENCE_BUF];

         // R8: conversion enables
         repeat_conversion_enable   <= low_power_config_reg[`LPC_REPEAT_CONV];
         conversion_enable          <= low_power_config_reg[`LPC_CONV];

         // R9: fast power-downs
         fast_reference_powerdown   <= low_power_config_reg[`LPC_FAST_REF_PD];
         fast_oscillator_powerdown  <= low_power_config_reg[`LPC_FAST_OSC_PD];
      end
   end

endmodule

`default_nettype wire

// ---- tb/lp_clock_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module lp_clock_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        sequencer_slow_request,
   input wire logic        sys_clk_use_slow,
   input wire logic [1:0]  sys_clk_source,
   input wire logic [5:0]  sys_clk_divide,
   input wire logic        sys_clk_tick,
   input wire logic        adc_clk_divided,
   input wire logic        fast_32m_to_digital,
   input wire logic        analog_regulator_powerdown,
   input wire logic        common_mode_buffer_enable,
   input wire logic        reference_buffer_enable,
   input wire logic        repeat_conversion_enable,
   input wire logic        conversion_enable,
   input wire logic        fast_reference_powerdown,
   input wire logic        fast_oscillator_powerdown
);
   logic [19:0] key_q;
   wire         wr_acc;
   wire         open_q;
   wire  [8:0]  lpc;
   assign wr_acc = psel && penable && pwrite;
   assign open_q = (key_q == 20'hC59D6);
   assign lpc = {analog_regulator_powerdown, common_mode_buffer_enable, reference_buffer_enable, 2'b00,
                 repeat_conversion_enable, conversion_enable, fast_reference_powerdown, fast_oscillator_powerdown};
   // ==========================================================================
   // Shadow copy of the low power key, as the bus has written it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= 20'h00000;
      end else if (wr_acc && paddr == 16'h210C) begin
         key_q <= pwdata[19:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================================
   // Assertions.
   chk_open_cfg_write:
      assert property (wr_acc && paddr == 16'h2114 && open_q |-> ##2 lpc == ($past(pwdata[8:0], 2) & 9'h1CF))
      else $error("config write while unlocked not applied");
   chk_locked_cfg_hold:
      assert property (wr_acc && paddr == 16'h2114 && !open_q |-> ##2 $stable(lpc))
      else $error("config changed by a locked write");
   chk_read_mirrors_cfg:
      assert property (psel && !penable && !pwrite && paddr == 16'h2114 |=> prdata == {23'h000000, lpc})
      else $error("config read differs from outputs");
   chk_slow_switch_cause:
      assert property ($rose(sys_clk_use_slow) |-> $past(sequencer_slow_request))
      else $error("slow clock switch without request");
   chk_divide_range:
      assert property (sys_clk_divide >= 6'h01 && sys_clk_divide <= 6'h20)
      else $error("effective divide out of range");
   chk_tick_spacing:
      assert property (sys_clk_tick && sys_clk_divide == 6'h02 && $stable(sys_clk_divide) |=> !sys_clk_tick)
      else $error("tick spacing wrong for divide by two");
   chk_adc_undivided:
      assert property (!adc_clk_divided)
      else $error("converter clock divided");
   chk_fast_not_digital:
      assert property (!fast_32m_to_digital)
      else $error("fast setting reaches digital clock");
   chk_reset_values:
      assert property (disable iff (1'b0) !presetn |-> analog_regulator_powerdown && fast_reference_powerdown
                       && sys_clk_source == 2'h0 && sys_clk_divide == 6'h01)
      else $error("wrong output values in reset");
   cover property (wr_acc && paddr == 16'h2114 && open_q);
   cover property (wr_acc && paddr == 16'h2114 && !open_q);
   cover property ($rose(sys_clk_use_slow));
endmodule
bind low_power_clock_key_control lp_clock_checker u_chk (.*);
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, sequencer_slow_request, general_pin_two, general_pin_five;
   logic [15:0] paddr, oscillator_control_out;
   logic [31:0] pwdata, prdata, seed, d;
   logic pready, pslverr, sys_clk_use_slow, sys_clk_tick, adc_clk_divided, ext_clk_level;
   logic sleep_timer_clk_enable, chop_clk_enable, analog_clk_enable, fast_32m_to_analog;
   logic fast_32m_to_digital, reset_control_unlocked, analog_regulator_powerdown;
   logic common_mode_buffer_enable, reference_buffer_enable, repeat_conversion_enable;
   logic conversion_enable, fast_reference_powerdown, fast_oscillator_powerdown;
   logic [1:0] sys_clk_source, adc_clk_source;
   logic [5:0] sys_clk_divide;
   logic [8:0] lpc;
   logic [32:0] exp_q[$];
   int fails, n_tests, i;
   logic [15:0] ra[13] = '{16'h0408, 16'h0410, 16'h0414, 16'h0420, 16'h0A0C, 16'h0A10, 16'h0A5C,
                           16'h0A6C, 16'h0A70, 16'h20BC, 16'h210C, 16'h2110, 16'h2114};
   logic [15:0] rv[13] = '{16'h0441, 16'h01C0, 16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0000,
                           16'h0088, 16'h0004, 16'h0034, 16'h0000, 16'h0000, 16'h0102};
   logic [5:0] dv[6] = '{6'h00, 6'h01, 6'h02, 6'h20, 6'h21, 6'h3F};
   logic [5:0] de[6] = '{6'h01, 6'h01, 6'h02, 6'h20, 6'h20, 6'h20};
   low_power_clock_key_control u_dut (.*);
   wire [8:0] lpc_out = {analog_regulator_powerdown, common_mode_buffer_enable, reference_buffer_enable,
                         2'b00, repeat_conversion_enable, conversion_enable, fast_reference_powerdown,
                         fast_oscillator_powerdown};
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================================================
   // APB master: one idle edge, setup, then access until pready.
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic [32:0] e);
      @(posedge pclk);
      if (!w) exp_q.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 33'h0);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask
   task automatic settle();
      repeat (2) @(posedge pclk);
   endtask
   // ==========================================================================
   // Read monitor: compares each completed read with the oldest note.
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
         check("read", {pslverr, prdata}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      complete_run();
   end
   initial begin
      {psel, penable, pwrite, sequencer_slow_request, general_pin_two, general_pin_five} = 6'h00;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      fails = 0;
      n_tests = 0;
      seed = 32'd6260;
      presetn = 1'b1;
      #1 presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 13; i++) rd(ra[i], {16'h0000, rv[i]});
      apb(1'b0, 16'h0004, 32'h0, 33'h100000000);
      check("lpc_out", lpc_out, 33'h102);
      check("sys_src", sys_clk_source, 33'h0);
      check("sleep_clk", sleep_timer_clk_enable, 33'h1);
      check("clk_en", {chop_clk_enable, analog_clk_enable, fast_32m_to_analog}, 33'h3);
      wr(16'h2114, 32'h000001CD);
      wr(16'h2110, 32'h00000001);
      rd(16'h2114, 32'h00000102);
      rd(16'h2110, 32'h00000000);
      wr(16'h210C, 32'h000C59D6);
      rd(16'h210C, 32'h000C59D6);
      for (i = 0; i < 8; i++) begin
         d = xs();
         lpc = d[8:0] & 9'h1CF;
         wr(16'h2114, d);
         settle();
         check("lpc_out", lpc_out, {24'h0, lpc});
         rd(16'h2114, {23'h0, lpc});
      end
      wr(16'h2110, 32'h00000001);
      rd(16'h2110, 32'h00000001);
      sequencer_slow_request <= 1'b1;
      repeat (3) @(posedge pclk);
      check("use_slow", sys_clk_use_slow, 33'h1);
      sequencer_slow_request <= 1'b0;
      repeat (3) @(posedge pclk);
      check("use_slow", sys_clk_use_slow, 33'h0);
      for (i = 0; i < 2; i++) begin
         wr(16'h210C, 32'h000C59D6);
         wr(16'h210C, i ? 32'h000C59D7 : 32'h00000000);
         wr(16'h2114, {23'h0, ~lpc});
         wr(16'h2110, 32'h00000000);
         rd(16'h2114, {23'h0, lpc});
         rd(16'h2110, 32'h00000001);
      end
      for (i = 0; i < 6; i++) begin
         wr(16'h0420, 32'h0000A815);
         wr(16'h0408, {26'h0000011, dv[i]});
         settle();
         check("divide", sys_clk_divide, {27'h0, de[i]});
      end
      wr(16'h0408, 32'h00000445);
      rd(16'h0408, 32'h0000047F);
      rd(16'h0420, 32'h00000000);
      wr(16'h0414, 32'h0000000F);
      wr(16'h0420, 32'h0000A815);
      wr(16'h0408, 32'h00000442);
      settle();
      check("adc_src", {adc_clk_source, sys_clk_source}, 33'hF);
      check("adc_div", adc_clk_divided, 33'h0);
      repeat (10) @(posedge pclk);
      wr(16'h0A10, 32'h00000000);
      rd(16'h0A10, 32'h00000003);
      wr(16'h0A0C, 32'h00000001);
      rd(16'h0A0C, 32'h00000001);
      wr(16'h0A10, 32'h00000005);
      rd(16'h0A10, 32'h00000005);
      check("osc_out", oscillator_control_out, 33'h5);
      wr(16'h0A5C, 32'h00000001);
      settle();
      check("rst_unlock", reset_control_unlocked, 33'h1);
      rd(16'h0A5C, 32'h00000000);
      wr(16'h0A5C, 32'h00000002);
      settle();
      check("rst_unlock", reset_control_unlocked, 33'h0);
      wr(16'h0A70, 32'h00000002);
      settle();
      check("sleep_clk", sleep_timer_clk_enable, 33'h0);
      general_pin_two <= 1'b1;
      repeat (8) @(posedge pclk);
      check("ext_clk", ext_clk_level, 33'h1);
      general_pin_two <= 1'b0;
      repeat (8) @(posedge pclk);
      check("ext_clk", ext_clk_level, 33'h0);
      general_pin_five <= 1'b1;
      repeat (8) @(posedge pclk);
      check("ext_clk", ext_clk_level, 33'h1);
      complete_run();
   end
endmodule
`default_nettype wire
